// ---- src/can_error_status.sv ----
`timescale 1ns/10ps
`include "can_err_defs.svh"
// Behaviour
// (RULE1) Queue head reads as two 16-bit halves
// (RULE2) Software reads queue head outside configuration
// (RULE3) Bus-off flag set when transmit count exceeds 255
// (RULE4) Configuration mode forces bus-off; resets set
// (RULE5) Transmit passive flag when count above 127
// (RULE6) Receive passive flag when count above 127
// (RULE7) Transmit warning for count 96 to 127
// (RULE8) Receive warning for count 96 to 127
// (RULE9) Combined warning is OR of both warnings
// (RULE10) Transmit count in bits 15..8, read-only
// (RULE11) Receive count in bits 7..0, read-only
// (RULE12) Flags register bits 15..6 read zero
// (RULE13) Counters follow fault confinement; flags combinational
module can_error_status (
    // Clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_arst_n,
    // Register bus
    input  wire can_err_pkg::avs_req_t   i_avs_req,
    output      can_err_pkg::avs_rsp_t   o_avs_rsp,
    // Protocol engine and queue logic
    input  wire can_err_pkg::fault_evt_t i_fault_evt,
    input  wire logic [31:0]             i_txq_head_addr,
    // Status towards the rest of the controller
    output      can_err_pkg::err_flags_t o_err_flags,
    output      logic                    o_cfg_mode,
    output      logic                    o_irq
);
    import can_err_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    bus_state_t  bus_state_q;
    logic [31:0] readdata_q;
    logic [31:0] read_mux;
    logic        cfg_mode_q;
    logic [8:0]  tx_cnt_q;
    logic [8:0]  rx_cnt_q;
    logic [8:0]  tx_sum;
    logic [8:0]  rx_sum;
    logic [7:0]  tx_cnt_view;
    logic [7:0]  recov_cnt_q;
    logic [31:0] txq_q;
    err_flags_t  flags;
    err_flags_t  flags_prev_q;
    logic [`IRQ_WIDTH-1:0] irq_status_q;
    logic [`IRQ_WIDTH-1:0] irq_mask_q;
    logic [`IRQ_WIDTH-1:0] irq_event;
    logic        bus_req;
    logic        wr_take;
    logic        rd_take;
    logic        recovered;

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // Every access answers with exactly one wait cycle
    assign bus_req = i_avs_req.read | i_avs_req.write;
    assign rd_take = i_avs_req.read & (bus_state_q == BUS_IDLE);
    assign wr_take = i_avs_req.write & (bus_state_q == BUS_ACK);
    assign o_avs_rsp.waitrequest = bus_req & (bus_state_q != BUS_ACK);
    assign o_avs_rsp.readdata = readdata_q;

    // Phase of the current access
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus_state_q <= BUS_IDLE;
        end else begin
            case (bus_state_q)
                BUS_IDLE: bus_state_q <= bus_req ? BUS_ACK : BUS_IDLE;
                BUS_ACK:  bus_state_q <= BUS_IDLE;
                default:  bus_state_q <= BUS_IDLE;
            endcase
        end
    end

    // Read selection; unmapped offsets read zero
    always_comb begin
        read_mux = 32'h0000_0000;
        case (i_avs_req.address)
            `REG_TXQ_HIGH:   read_mux = {16'h0000, txq_q[31:16]};   // [RULE1]
            `REG_TXQ_LOW:    read_mux = {16'h0000, txq_q[15:0]};    // [RULE1]
            `REG_ERR_FLAGS:  read_mux = {26'h0000000, flags};       // [RULE12]
            `REG_ERR_COUNTS: read_mux = {16'h0000, tx_cnt_view, rx_cnt_q[7:0]}; // [RULE10] [RULE11]
            `REG_CTRL:       read_mux = {31'h00000000, cfg_mode_q};
            `REG_IRQ_STATUS: read_mux = {27'h0000000, irq_status_q};
            `REG_IRQ_MASK:   read_mux = {27'h0000000, irq_mask_q};
            default:         read_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the wait cycle and held until the next read
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            readdata_q <= read_mux;
        end
    end

    // Queue head is sampled every cycle; during configuration the queue
    // logic may be rebuilding, so software must not trust it then [RULE2]
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            txq_q <= 32'h0000_0000;
        end else begin
            txq_q <= i_txq_head_addr;   // [RULE1]
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Configuration mode after reset keeps the node off the bus
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_mode_q <= `CTRL_RESET;  // [RULE4]
        end else if (wr_take && i_avs_req.address == `REG_CTRL) begin
            cfg_mode_q <= i_avs_req.writedata[`CTRL_CFG_BIT];
        end
    end
    assign o_cfg_mode = cfg_mode_q;

    // ************************************************************
    // Fault confinement counters
    // ************************************************************
    // Nine bits so that a count past 255 is representable as bus-off
    assign tx_sum = tx_cnt_q + `CNT_STEP_MAJOR;
    assign rx_sum = rx_cnt_q + (i_fault_evt.rx_err_major ? `CNT_STEP_MAJOR
                                                         : `CNT_STEP_MINOR);
    assign recovered = tx_cnt_q[8] & i_fault_evt.idle_seq &
                       (recov_cnt_q == `RECOVERY_SEQS - 8'h01);

    // Transmit counter; errors outrank successes in the same cycle
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_cnt_q <= 9'h000;
        end else if (cfg_mode_q || recovered) begin
            tx_cnt_q <= 9'h000;
        end else if (!tx_cnt_q[8]) begin
            if (i_fault_evt.tx_err) begin
                tx_cnt_q <= (tx_sum > `CNT_BUSOFF_VAL) ? `CNT_BUSOFF_VAL : tx_sum; // [RULE13]
            end else if (i_fault_evt.tx_ok && tx_cnt_q != 9'h000) begin
                tx_cnt_q <= tx_cnt_q - `CNT_STEP_MINOR;  // [RULE13]
            end
        end
    end

    // Receive counter, frozen while bus-off
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_cnt_q <= 9'h000;
        end else if (cfg_mode_q || recovered) begin
            rx_cnt_q <= 9'h000;
        end else if (!tx_cnt_q[8]) begin
            if (i_fault_evt.rx_err || i_fault_evt.rx_err_major) begin
                rx_cnt_q <= (rx_sum > `CNT_RX_MAX) ? `CNT_RX_MAX : rx_sum; // [RULE13]
            end else if (i_fault_evt.rx_ok) begin
                if (rx_cnt_q > `CNT_PASSIVE_ABOVE) begin
                    rx_cnt_q <= `CNT_RX_RELOAD;  // [RULE13]
                end else if (rx_cnt_q != 9'h000) begin
                    rx_cnt_q <= rx_cnt_q - `CNT_STEP_MINOR;
                end
            end
        end
    end

    // Idle sequences seen while bus-off; the set number ends bus-off
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            recov_cnt_q <= 8'h00;
        end else if (!tx_cnt_q[8] || cfg_mode_q) begin
            recov_cnt_q <= 8'h00;
        end else if (i_fault_evt.idle_seq) begin
            recov_cnt_q <= recov_cnt_q + 8'h01;  // [RULE13]
        end
    end

    // Eight-bit view saturates so bus-off never reads as a small count
    assign tx_cnt_view = tx_cnt_q[8] ? 8'hFF : tx_cnt_q[7:0];

    // ************************************************************
    // Error state flags
    // ************************************************************
    // Decoded straight from the counters, no extra latency
    always_comb begin
        flags.tx_bus_off_flag     = (tx_cnt_q > `CNT_BUSOFF_ABOVE) | cfg_mode_q; // [RULE3] [RULE4]
        flags.tx_bus_passive_flag = tx_cnt_q > `CNT_PASSIVE_ABOVE;               // [RULE5]
        flags.rx_bus_passive_flag = rx_cnt_q > `CNT_PASSIVE_ABOVE;               // [RULE6]
        flags.tx_warning_flag     = (tx_cnt_q > `CNT_WARN_ABOVE) &&
                                    (tx_cnt_q <= `CNT_PASSIVE_ABOVE);            // [RULE7]
        flags.rx_warning_flag     = (rx_cnt_q > `CNT_WARN_ABOVE) &&
                                    (rx_cnt_q <= `CNT_PASSIVE_ABOVE);            // [RULE8]
        flags.any_warning_flag    = flags.tx_warning_flag |
                                    flags.rx_warning_flag;                       // [RULE9]
    end
    assign o_err_flags = flags;

    // ************************************************************
    // Interrupts
    // ************************************************************
    // Previous flags; reset matches the configuration-mode view
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_prev_q <= err_flags_t'(6'h20);
        end else begin
            flags_prev_q <= flags;
        end
    end

    // Entry into the combined warning state, each passive state and bus-off, plus recovery from bus-off; forced bus-off in configuration is no event
    always_comb begin
        irq_event = '0;
        irq_event[`IRQ_WARN_BIT]    = flags.any_warning_flag & ~flags_prev_q.any_warning_flag;
        irq_event[`IRQ_TX_BUS_PASSIVE_FLAG_BIT]    = flags.tx_bus_passive_flag &
                                      ~flags_prev_q.tx_bus_passive_flag;
        irq_event[`IRQ_RX_BUS_PASSIVE_FLAG_BIT]    = flags.rx_bus_passive_flag &
                                      ~flags_prev_q.rx_bus_passive_flag;
        irq_event[`IRQ_BUSOFF_BIT]  = flags.tx_bus_off_flag & ~flags_prev_q.tx_bus_off_flag &
                                      ~cfg_mode_q;
        irq_event[`IRQ_RECOVER_BIT] = recovered;
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_status_q <= `IRQ_RESET;
        end else if (wr_take && i_avs_req.address == `REG_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~i_avs_req.writedata[`IRQ_WIDTH-1:0]) | irq_event;
        end else begin
            irq_status_q <= irq_status_q | irq_event;
        end
    end

    // Mask register, a one enables the source
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_mask_q <= `IRQ_RESET;
        end else if (wr_take && i_avs_req.address == `REG_IRQ_MASK) begin
            irq_mask_q <= i_avs_req.writedata[`IRQ_WIDTH-1:0];
        end
    end

    assign o_irq = |(irq_status_q & irq_mask_q);

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_txq_read;
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_avs_req.read && !o_avs_rsp.waitrequest && i_avs_req.address == `REG_TXQ_HIGH)
        |-> o_avs_rsp.readdata == {16'h0000, $past(i_txq_head_addr[31:16], 2)};
    endproperty
    a_txq_read: assert property (p_txq_read) // [RULE1]
        else $error("queue head high half wrong");

    property p_busoff;
        @(posedge i_clock) disable iff (!i_arst_n)
        (tx_cnt_q > `CNT_BUSOFF_ABOVE) |-> o_err_flags.tx_bus_off_flag;
    endproperty
    a_busoff: assert property (p_busoff) // [RULE3]
        else $error("bus-off flag missing");

    property p_cfg_busoff;
        @(posedge i_clock) disable iff (!i_arst_n)
        // Counters clear on the edge after the mode bit is seen, not at once
        o_cfg_mode |-> o_err_flags.tx_bus_off_flag ##1 tx_cnt_q == 9'h000;
    endproperty
    a_cfg_busoff: assert property (p_cfg_busoff) // [RULE4]
        else $error("configuration mode not shown as bus-off");

    property p_tx_passive;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_err_flags.tx_bus_passive_flag == (tx_cnt_q > 9'h07F);
    endproperty
    a_tx_passive: assert property (p_tx_passive) // [RULE5]
        else $error("transmit passive flag wrong");

    property p_rx_passive;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_err_flags.rx_bus_passive_flag == (rx_cnt_q > 9'h07F);
    endproperty
    a_rx_passive: assert property (p_rx_passive) // [RULE6]
        else $error("receive passive flag wrong");

    property p_tx_warn;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_err_flags.tx_warning_flag == (tx_cnt_q >= 9'h060 && tx_cnt_q < 9'h080);
    endproperty
    a_tx_warn: assert property (p_tx_warn) // [RULE7]
        else $error("transmit warning flag wrong");

    property p_rx_warn;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_err_flags.rx_warning_flag == (rx_cnt_q >= 9'h060 && rx_cnt_q < 9'h080);
    endproperty
    a_rx_warn: assert property (p_rx_warn) // [RULE8]
        else $error("receive warning flag wrong");

    property p_any_warn;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_err_flags.any_warning_flag ==
            (o_err_flags.tx_warning_flag || o_err_flags.rx_warning_flag);
    endproperty
    a_any_warn: assert property (p_any_warn) // [RULE9]
        else $error("combined warning flag wrong");

    property p_count_read;
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_avs_req.read && !o_avs_rsp.waitrequest && i_avs_req.address == `REG_ERR_COUNTS)
        |-> o_avs_rsp.readdata[31:16] == 16'h0000 &&
            o_avs_rsp.readdata[15:8] == ($past(tx_cnt_q[8]) ? 8'hFF
                                                            : $past(tx_cnt_q[7:0])) &&
            o_avs_rsp.readdata[7:0] == $past(rx_cnt_q[7:0]);
    endproperty
    a_count_read: assert property (p_count_read) // [RULE10] [RULE11]
        else $error("error count readback wrong");

    property p_flags_read;
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_avs_req.read && !o_avs_rsp.waitrequest && i_avs_req.address == `REG_ERR_FLAGS)
        |-> o_avs_rsp.readdata[31:6] == 26'h0000000;
    endproperty
    a_flags_read: assert property (p_flags_read) // [RULE12]
        else $error("unimplemented flag bits not zero");

    property p_tx_step;
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_fault_evt.tx_err && !o_cfg_mode && tx_cnt_q < 9'h0F8)
        |=> tx_cnt_q == $past(tx_cnt_q) + 9'h008;
    endproperty
    a_tx_step: assert property (p_tx_step) // [RULE13]
        else $error("transmit counter did not step by eight");

endmodule : can_error_status

// ---- src/can_err_defs.svh ----
`ifndef CAN_ERR_DEFS_SVH
`define CAN_ERR_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define REG_TXQ_HIGH     5'h00
`define REG_TXQ_LOW      5'h04
`define REG_ERR_FLAGS    5'h08
`define REG_ERR_COUNTS   5'h0C
`define REG_CTRL         5'h10
`define REG_IRQ_STATUS   5'h14
`define REG_IRQ_MASK     5'h18

// ************************************************************
// Field positions and reset values
// ************************************************************
`define CTRL_CFG_BIT     0
`define CTRL_RESET       1'b1
`define IRQ_WIDTH        5
`define IRQ_WARN_BIT     0
`define IRQ_TX_BUS_PASSIVE_FLAG_BIT     1
`define IRQ_RX_BUS_PASSIVE_FLAG_BIT     2
`define IRQ_BUSOFF_BIT   3
`define IRQ_RECOVER_BIT  4
`define IRQ_RESET        5'h00

// ************************************************************
// Fault confinement thresholds and steps
// ************************************************************
`define CNT_WARN_ABOVE   9'h05F
`define CNT_PASSIVE_ABOVE 9'h07F
`define CNT_BUSOFF_ABOVE 9'h0FF
`define CNT_BUSOFF_VAL   9'h100
`define CNT_RX_MAX       9'h0FF
`define CNT_STEP_MAJOR   9'h008
`define CNT_STEP_MINOR   9'h001
`define CNT_RX_RELOAD    9'h078
`define RECOVERY_SEQS    8'h80

`endif

// ---- src/can_err_pkg.sv ----
package can_err_pkg;

    // ************************************************************
    // Shared types
    // ************************************************************
    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avs_rsp_t;

    // Pulses from the bit-level protocol engine
    typedef struct packed {
        logic tx_err;
        logic tx_ok;
        logic rx_err;
        logic rx_err_major;
        logic rx_ok;
        logic idle_seq;
    } fault_evt_t;

    // Order matches the error state flags register, bit 5 down to 0
    typedef struct packed {
        logic tx_bus_off_flag;
        logic tx_bus_passive_flag;
        logic rx_bus_passive_flag;
        logic tx_warning_flag;
        logic rx_warning_flag;
        logic any_warning_flag;
    } err_flags_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

endpackage : can_err_pkg

// ---- dv/can_bus_nodes.sv ----
`timescale 1ns/10ps
// ************************************************************
// Other nodes on the shared bus, seen as fault events
// ************************************************************
module can_bus_nodes (
    // Clock
    input  wire logic              i_clock,
    // Events towards the status block
    output can_err_pkg::fault_evt_t o_evt
);
    import can_err_pkg::*;

    // Quiet bus until a scenario asks for traffic
    initial o_evt = '0;

    // One pulse per event; gap idles between pulses model a slow bus
    task automatic emit(input int k, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clock);
            o_evt <= fault_evt_t'(6'h20 >> k);
            repeat (gap) begin
                @(posedge i_clock);
                o_evt <= '0;
            end
        end
        @(posedge i_clock);
        o_evt <= '0;
    endtask : emit
endmodule : can_bus_nodes

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`include "can_err_defs.svh"
module testbench;
    import can_err_pkg::*;

    // ************************************************************
    // Signals and reference state
    // ************************************************************
    logic        i_clock;
    logic        i_arst_n;
    avs_req_t    req;
    avs_rsp_t    rsp;
    fault_evt_t  evt;
    err_flags_t  flags;
    logic [31:0] head;
    logic        cfg_o;
    logic        irq;
    int          mismatches;
    int          comparisons;
    int          tec;
    int          rec;
    int          busoff;
    int          idles;
    logic        cfg_m;
    logic [31:0] q;

    can_error_status dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_avs_req(req),
        .o_avs_rsp(rsp), .i_fault_evt(evt), .i_txq_head_addr(head),
        .o_err_flags(flags), .o_cfg_mode(cfg_o), .o_irq(irq));
    can_bus_nodes nodes (.i_clock(i_clock), .o_evt(evt));

    // Clock at 50 ns
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // ************************************************************
    // Checking and reporting
    // ************************************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Avalon access; holds everything until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        req <= '{address: a, read: !w, write: w, writedata: d};
        do begin
            @(posedge i_clock);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 40);
        if (rsp.waitrequest !== 1'b0) begin
            mismatches++;
            test_done();
        end
        q = rsp.readdata;
        req <= '0;
        // A write lands in this edge's update; let it settle before callers look
        @(negedge i_clock);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(q, e);
    endtask : rd

    // ************************************************************
    // Reference fault confinement model
    // ************************************************************
    function automatic logic [5:0] exp_flags();
        logic tw;
        logic rw;
        tw = tec > 95 && tec < 128;
        rw = rec > 95 && rec < 128;
        return {cfg_m | tec > 255, tec > 127, rec > 127, tw, rw, tw | rw};
    endfunction : exp_flags

    // Kinds: 0 tx_err, 1 tx_ok, 2 rx_err, 3 rx major, 4 rx_ok, 5 idle
    task automatic step(input int k);
        if (cfg_m) return;
        if (busoff != 0) begin
            if (k == 5) idles++;
            if (idles == 128) begin
                tec = 0;
                rec = 0;
                busoff = 0;
                idles = 0;
            end
        end else begin
            case (k)
                0: begin
                    tec += 8;
                    if (tec > 255) begin
                        tec = 256;
                        busoff = 1;
                    end
                end
                1: tec = tec > 0 ? tec - 1 : 0;
                2: rec = rec < 255 ? rec + 1 : 255;
                3: rec = rec > 247 ? 255 : rec + 8;
                4: rec = rec > 127 ? 120 : (rec > 0 ? rec - 1 : 0);
                default: ;
            endcase
        end
    endtask : step

    // Odd counts arrive with idle gaps, even counts back to back
    task automatic ev(input int k, input int n);
        for (int i = 0; i < n; i++) step(k);
        nodes.emit(k, n, n % 2);
    endtask : ev

    task automatic chk();
        rd(`REG_ERR_FLAGS, {26'h0, exp_flags()});
        rd(`REG_ERR_COUNTS, {16'h0, tec > 255 ? 8'hFF : 8'(tec), 8'(rec)});
        cmp({26'h0, flags}, {26'h0, exp_flags()});
        cmp(32'(cfg_o), 32'(cfg_m));
    endtask : chk

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        i_arst_n = 1'b0;
        req = '0;
        head = 32'hA5C3_1E7F;
        cfg_m = 1'b1;
        {tec, rec, busoff, idles, mismatches, comparisons} = '0;
        repeat (2) @(posedge i_clock);
        i_arst_n <= 1'b1;
        chk();
        ev(0, 3);
        chk();
        bus(1'b1, `REG_CTRL, 32'h0);
        cfg_m = 1'b0;
        chk();
        rd(`REG_TXQ_HIGH, 32'h0000_A5C3);
        rd(`REG_TXQ_LOW, 32'h0000_1E7F);
        head <= 32'h5A3C_E180;
        rd(`REG_TXQ_HIGH, 32'h0000_5A3C);
        rd(`REG_TXQ_LOW, 32'h0000_E180);
        rd(5'h1C, 32'h0);
        // Receive side through warning, passive and the reload
        ev(3, 12);
        bus(1'b1, `REG_ERR_COUNTS, 32'hFFFF_FFFF);
        chk();
        rd(`REG_IRQ_STATUS, 32'h1);
        cmp(32'(irq), 32'h0);
        bus(1'b1, `REG_IRQ_MASK, 32'h1);
        cmp(32'(irq), 32'h1);
        bus(1'b1, `REG_IRQ_STATUS, 32'h1);
        cmp(32'(irq), 32'h0);
        ev(4, 1);
        chk();
        ev(2, 33);
        chk();
        ev(4, 1);
        chk();
        // Transmit side across every threshold edge
        ev(0, 12);
        chk();
        ev(1, 1);
        chk();
        ev(0, 4);
        chk();
        ev(0, 1);
        chk();
        ev(0, 15);
        chk();
        ev(0, 1);
        chk();
        // Bus-off ignores traffic until recovery completes
        ev(2, 3);
        ev(5, 127);
        chk();
        ev(5, 1);
        chk();
        rd(`REG_IRQ_STATUS, 32'h1F);
        bus(1'b1, `REG_IRQ_MASK, 32'h1F);
        cmp(32'(irq), 32'h1);
        bus(1'b1, `REG_IRQ_STATUS, 32'h1F);
        cmp(32'(irq), 32'h0);
        // Back into configuration clears counters and forces bus-off
        ev(0, 12);
        bus(1'b1, `REG_CTRL, 32'h1);
        {cfg_m, tec, rec} = {1'b1, 64'h0};
        chk();
        test_done();
    end
endmodule : testbench
